// ---- sim/nvm_fabric_reader.sv ----
// fabric logic model that reads the byte store
`default_nettype none

module nvm_fabric_reader (
	input  wire logic       go_in,
	input  wire logic [6:0] addr_in,
	output logic            rd_en_out,
	output logic      [6:0] rd_addr_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// address scrambled while idle
	assign rd_en_out = go_in;
	assign rd_addr_out = go_in ? addr_in : ~addr_in;
endmodule : nvm_fabric_reader

`default_nettype wire

// ---- sim/tb_user_nvm_byte_read_port.sv ----
// self-checking bench for the user byte store
`default_nettype none
`include "user_nvm_map.svh"

module tb_user_nvm_byte_read_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_in = 0, rst_n_in = 0, go = 0, fab_wr_in = 0, fab_erase_in = 0, rd_en_in;
	logic prog_mode_in = 0, prog_decrypt_in = 0, prog_wr_in = 0, prog_erase_in = 0, prog_rd_in = 0;
	logic fab_refused_out, prog_rvalid_out, prog_busy_out;
	logic [6:0] rd_addr_in, addr = 0, prog_addr_in = 0, last;
	logic [7:0] rd_data_out, prog_wdata_in = 0, prog_rdata_out, user_out_in = 0, user_oe_in = 0;
	logic [7:0] io_out_out, io_oe_n_out, io_pullup_out, k, mem [128];
	logic [2:0] rd_bank_out;
	int seed = 23799, fails = 0, checks_done = 0;

	always #50 ref_clk_in = ~ref_clk_in;

	user_nvm_byte_read_port DUT (.ref_clk_in, .rst_n_in, .rd_en_in, .rd_addr_in, .rd_data_out,
		.rd_bank_out, .fab_wr_in, .fab_erase_in, .fab_refused_out, .prog_mode_in, .prog_decrypt_in,
		.prog_wr_in, .prog_erase_in, .prog_rd_in, .prog_addr_in, .prog_wdata_in, .prog_rdata_out,
		.prog_rvalid_out, .prog_busy_out, .user_out_in, .user_oe_in, .io_out_out, .io_oe_n_out,
		.io_pullup_out);
	nvm_fabric_reader reader (.go_in(go), .addr_in(addr), .rd_en_out(rd_en_in),
		.rd_addr_out(rd_addr_in));

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic prog(input logic w, e, r, x, input logic [6:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		prog_wr_in <= w;
		prog_erase_in <= e;
		prog_rd_in <= r;
		prog_decrypt_in <= x;
		prog_addr_in <= a;
		prog_wdata_in <= d;
	endtask : prog

	task automatic pread(input logic [6:0] a, input logic [7:0] exp);
		prog(1'b0, 1'b0, 1'b1, 1'b0, a, 8'h00);
		prog(1'b0, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
		#1 chk({7'h0, prog_rvalid_out}, 8'h01);
		chk(prog_rdata_out, exp);
	endtask : pread

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	initial begin
		#400000;
		fails++;
		finish_test();
	end

	initial begin
		user_out_in <= 8'($random(seed));
		user_oe_in <= 8'($random(seed));
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1;
		#1 chk(rd_data_out, `NVM_RD_DATA_RST);
		chk(io_oe_n_out, 8'hff);
		@(posedge ref_clk_in);
		prog_mode_in <= 1;
		for (int b = 0; b < 8; b++) begin
			prog(1'b0, 1'b1, 1'b0, 1'b0, {b[2:0], 4'h0}, 8'h00);
			pread({b[2:0], 4'hf}, `NVM_ERASED_BYTE);
		end
		chk({7'h0, prog_busy_out}, 8'h01);
		chk(io_pullup_out, 8'hff);
		$display("test erase done");
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'($random(seed));
			prog(1'b1, 1'b0, 1'b0, 1'b0, i[6:0], mem[i]);
		end
		prog(1'b1, 1'b1, 1'b0, 1'b0, 7'h70, 8'h12);
		for (int i = 112; i < 128; i++) mem[i] = `NVM_ERASED_BYTE;
		k = `NVM_KEY_SEED;
		for (int i = 3; i < 5; i++) begin
			prog(1'b1, 1'b0, 1'b0, 1'b1, i[6:0], mem[i]);
			mem[i] = mem[i] ^ k;
			k = lfsr_next(k);
		end
		pread(7'h04, mem[4]);
		pread(7'h7f, mem[127]);
		@(posedge ref_clk_in);
		prog_mode_in <= 0;
		repeat (3) @(posedge ref_clk_in);
		#1 chk({7'h0, prog_busy_out}, 8'h00);
		chk(io_oe_n_out, ~user_oe_in);
		chk(io_out_out, user_out_in);
		$display("test program done");
		prog(1'b0, 1'b1, 1'b0, 1'b0, 7'h00, 8'h00);
		prog(1'b0, 1'b0, 1'b0, 1'b0, 7'h00, 8'h00);
		rst_n_in <= 1'b0;
		@(posedge ref_clk_in);
		#1 chk(prog_rdata_out, `NVM_PROG_DATA_RST);
		chk(io_out_out, 8'h00);
		@(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i <= 128; i++) begin
			@(posedge ref_clk_in);
			go <= i < 128;
			addr <= i[6:0] ^ 7'h2a;
			fab_wr_in <= 1'($random(seed));
			fab_erase_in <= 1'($random(seed));
			#1 if (i > 0) chk(rd_data_out, mem[last]);
			if (i > 0) chk({5'h0, rd_bank_out}, {5'h0, last[6:4]});
			if (i < 128) last = i[6:0] ^ 7'h2a;
		end
		repeat (4) @(posedge ref_clk_in);
		#1 chk(rd_data_out, mem[last]);
		$display("test fabric read done");
		finish_test();
	end
endmodule : tb_user_nvm_byte_read_port

`default_nettype wire

// ---- sim/user_nvm_properties.sv ----
// port assertions for the user byte store
`default_nettype none

module user_nvm_properties #(
	parameter int IO_W = 8
) (
	input wire logic            ref_clk_in,
	input wire logic            rst_n_in,
	input wire logic            rd_en_in,
	input wire logic [6:0]      rd_addr_in,
	input wire logic [7:0]      rd_data_out,
	input wire logic [2:0]      rd_bank_out,
	input wire logic            fab_wr_in,
	input wire logic            fab_erase_in,
	input wire logic            fab_refused_out,
	input wire logic            prog_mode_in,
	input wire logic            prog_rd_in,
	input wire logic            prog_rvalid_out,
	input wire logic            prog_busy_out,
	input wire logic [IO_W-1:0] user_oe_in,
	input wire logic [IO_W-1:0] io_oe_n_out,
	input wire logic [IO_W-1:0] io_pullup_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	property p_rd_bank; rd_en_in |=> rd_bank_out == $past(rd_addr_in[6:4]); endproperty
	a_rd_bank: assert property (p_rd_bank) else $error("read bank wrong");
	property p_rd_hold; !rd_en_in |=> $stable(rd_data_out) && $stable(rd_bank_out); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read byte not held");
	property p_refuse; fab_wr_in || fab_erase_in |=> fab_refused_out; endproperty
	a_refuse: assert property (p_refuse) else $error("fabric alter not refused");
	property p_no_refuse; !(fab_wr_in || fab_erase_in) |=> !fab_refused_out; endproperty
	a_no_refuse: assert property (p_no_refuse) else $error("spurious refusal");
	property p_open; prog_mode_in && !prog_busy_out |=> prog_busy_out; endproperty
	a_open: assert property (p_open) else $error("session did not open");
	property p_close;
		prog_busy_out && !prog_mode_in ##1 !prog_mode_in |=> !prog_busy_out;
	endproperty
	a_close: assert property (p_close) else $error("session did not close");
	property p_rd_back;
		prog_mode_in && $past(prog_mode_in) && prog_busy_out && prog_rd_in |=> prog_rvalid_out;
	endproperty
	a_rd_back: assert property (p_rd_back) else $error("readback missing");
	property p_no_rvalid; !prog_rd_in |=> !prog_rvalid_out; endproperty
	a_no_rvalid: assert property (p_no_rvalid) else $error("readback unasked");
	property p_held; prog_mode_in |=> io_oe_n_out == '1 && io_pullup_out == '1; endproperty
	a_held: assert property (p_held) else $error("pins not floated");
	property p_free;
		!prog_mode_in && !prog_busy_out |=> io_oe_n_out == ~$past(user_oe_in) && io_pullup_out == '0;
	endproperty
	a_free: assert property (p_free) else $error("pins not released");
endmodule : user_nvm_properties

bind user_nvm_byte_read_port user_nvm_properties #(.IO_W(IO_W)) props (
	.ref_clk_in, .rst_n_in, .rd_en_in, .rd_addr_in, .rd_data_out, .rd_bank_out,
	.fab_wr_in, .fab_erase_in, .fab_refused_out, .prog_mode_in, .prog_rd_in,
	.prog_rvalid_out, .prog_busy_out, .user_oe_in, .io_oe_n_out, .io_pullup_out
);

`default_nettype wire

// ---- verilog/nvm_bank_array.sv ----
// banked byte storage with one program port and two read ports
`default_nettype none
`include "user_nvm_map.svh"

module nvm_bank_array #(
	parameter int BANKS          = `NVM_BANKS,
	parameter int BYTES_PER_BANK = `NVM_BYTES_PER_BANK
) (
	input  wire logic                     clk_in,
	input  wire logic                     wr_en_in,
	input  wire logic [`NVM_ADDR_W-1:0]   wr_addr_in,
	input  wire logic [`NVM_DATA_W-1:0]   wr_data_in,
	input  wire logic                     erase_en_in,
	input  wire logic [`NVM_BANK_W-1:0]   erase_bank_in,
	input  wire logic [`NVM_ADDR_W-1:0]   rd_a_addr_in,
	output logic      [`NVM_DATA_W-1:0]   rd_a_data_out,
	input  wire logic [`NVM_ADDR_W-1:0]   rd_b_addr_in,
	output logic      [`NVM_DATA_W-1:0]   rd_b_data_out
);

	localparam int DEPTH = BANKS * BYTES_PER_BANK;

	// contents carry no reset: they survive it
	logic [`NVM_DATA_W-1:0] mem [0:DEPTH-1];
	wire  [DEPTH-1:0]       erase_hit;
	wire  [DEPTH-1:0]       write_hit;

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_cell
			localparam int CELL = g;
			assign erase_hit[g] = erase_en_in &&
				(erase_bank_in == user_nvm_pkg::bank_of(CELL[`NVM_ADDR_W-1:0]));
			assign write_hit[g] = wr_en_in && (wr_addr_in == CELL[`NVM_ADDR_W-1:0]);
		end
	endgenerate

	// erase of a bank wins over a write into it
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (erase_hit[i]) begin
				mem[i] <= `NVM_ERASED_BYTE;
			end else if (write_hit[i]) begin
				mem[i] <= wr_data_in;
			end
		end
	end

	assign rd_a_data_out = mem[rd_a_addr_in];
	assign rd_b_data_out = mem[rd_b_addr_in];

endmodule : nvm_bank_array

`default_nettype wire

// ---- verilog/user_nvm_byte_read_port.sv ----
// user nonvolatile byte store: fabric read port, programming port, pin control
// Overview of operation
// - one kilobit store, eight banks of 128 bits; bank is the erase unit
// - fabric reads one byte per access on a synchronous clocked port
// - upper three address bits pick bank, lower four pick byte
// - erase and write only from the programming port, never the fabric
// - contents readable from both programming port and fabric address
// - store programmable alone, optional on-chip decryption of incoming bytes
// - during programming every user pin floats with weak pull-up
`default_nettype none
`include "user_nvm_map.svh"

module user_nvm_byte_read_port #(
	parameter int                     IO_W     = `NVM_IO_W,
	parameter logic [`NVM_DATA_W-1:0] KEY_SEED = `NVM_KEY_SEED
) (
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_n_in,
	// fabric read port
	input  wire logic                   rd_en_in,
	input  wire logic [`NVM_ADDR_W-1:0] rd_addr_in,
	output logic      [`NVM_DATA_W-1:0] rd_data_out,
	output logic      [`NVM_BANK_W-1:0] rd_bank_out,
	// fabric attempts to alter the store
	input  wire logic                   fab_wr_in,
	input  wire logic                   fab_erase_in,
	output logic                        fab_refused_out,
	// programming port
	input  wire logic                   prog_mode_in,
	input  wire logic                   prog_decrypt_in,
	input  wire logic                   prog_wr_in,
	input  wire logic                   prog_erase_in,
	input  wire logic                   prog_rd_in,
	input  wire logic [`NVM_ADDR_W-1:0] prog_addr_in,
	input  wire logic [`NVM_DATA_W-1:0] prog_wdata_in,
	output logic      [`NVM_DATA_W-1:0] prog_rdata_out,
	output logic                        prog_rvalid_out,
	output logic                        prog_busy_out,
	// user pins
	input  wire logic [IO_W-1:0]        user_out_in,
	input  wire logic [IO_W-1:0]        user_oe_in,
	output logic      [IO_W-1:0]        io_out_out,
	output logic      [IO_W-1:0]        io_oe_n_out,
	output logic      [IO_W-1:0]        io_pullup_out
);

	user_nvm_pkg::session_type state;
	user_nvm_pkg::session_type next_state;

	logic [`NVM_DATA_W-1:0] key_stream;
	logic [`NVM_DATA_W-1:0] next_key_stream;
	logic                   next_busy;

	// decode
	wire session_active = (state == user_nvm_pkg::session_open);
	wire store_write    = session_active && prog_wr_in && !prog_erase_in;
	wire store_erase    = session_active && prog_erase_in;
	wire prog_read      = session_active && prog_rd_in;
	wire fab_attempt    = fab_wr_in || fab_erase_in;
	wire pins_held      = prog_mode_in || (state != user_nvm_pkg::session_idle);

	wire [`NVM_BANK_W-1:0] erase_bank = user_nvm_pkg::bank_of(prog_addr_in);
	wire [`NVM_BANK_W-1:0] read_bank  = user_nvm_pkg::bank_of(rd_addr_in);

	wire key_feedback = key_stream[7] ^ key_stream[5] ^ key_stream[4] ^ key_stream[3];
	wire [`NVM_DATA_W-1:0] key_advanced = {key_stream[6:0], key_feedback};

	// optional decryption of incoming bytes
	wire [`NVM_DATA_W-1:0] store_data = prog_decrypt_in ?
		(prog_wdata_in ^ key_stream) : prog_wdata_in;

	wire [`NVM_DATA_W-1:0] fabric_byte;
	wire [`NVM_DATA_W-1:0] prog_byte;

	nvm_bank_array #(
		.BANKS          (`NVM_BANKS),
		.BYTES_PER_BANK (`NVM_BYTES_PER_BANK)
	) u_store (
		.clk_in        (ref_clk_in),
		.wr_en_in      (store_write),
		.wr_addr_in    (prog_addr_in),
		.wr_data_in    (store_data),
		.erase_en_in   (store_erase),
		.erase_bank_in (erase_bank),
		.rd_a_addr_in  (rd_addr_in),
		.rd_a_data_out (fabric_byte),
		.rd_b_addr_in  (prog_addr_in),
		.rd_b_data_out (prog_byte)
	);

	// programming session sequencing
	always_comb begin
		next_state = state;
		case (state)
			user_nvm_pkg::session_idle: begin
				if (prog_mode_in) begin
					next_state = user_nvm_pkg::session_open;
				end
			end
			user_nvm_pkg::session_open: begin
				if (!prog_mode_in) begin
					next_state = user_nvm_pkg::session_closing;
				end
			end
			user_nvm_pkg::session_closing: begin
				next_state = user_nvm_pkg::session_idle;
			end
			default: begin
				next_state = user_nvm_pkg::session_idle;
			end
		endcase
	end

	// keystream restarts per session, steps per decrypted byte
	always_comb begin
		next_key_stream = key_stream;
		if (state == user_nvm_pkg::session_idle) begin
			next_key_stream = KEY_SEED;
		end else if (store_write && prog_decrypt_in) begin
			next_key_stream = key_advanced;
		end
	end

	assign next_busy = (next_state != user_nvm_pkg::session_idle);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= user_nvm_pkg::session_idle;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			key_stream <= KEY_SEED;
		end else begin
			key_stream <= next_key_stream;
		end
	end

	// fabric read port
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= `NVM_RD_DATA_RST;
		end else if (rd_en_in) begin
			rd_data_out <= fabric_byte;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_bank_out <= '0;
		end else if (rd_en_in) begin
			rd_bank_out <= read_bank;
		end
	end

	// fabric has no alter path; attempts only flagged
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fab_refused_out <= 1'b0;
		end else begin
			fab_refused_out <= fab_attempt;
		end
	end

	// programming port readback
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prog_rvalid_out <= 1'b0;
		end else begin
			prog_rvalid_out <= prog_read;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prog_rdata_out <= `NVM_PROG_DATA_RST;
		end else if (prog_read) begin
			prog_rdata_out <= prog_byte;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prog_busy_out <= 1'b0;
		end else begin
			prog_busy_out <= next_busy;
		end
	end

	// user pins float with pull-up while programming
	wire [IO_W-1:0] next_io_out    = pins_held ? '0 : user_out_in;
	wire [IO_W-1:0] next_io_oe_n   = pins_held ? '1 : ~user_oe_in;
	wire [IO_W-1:0] next_io_pullup = pins_held ? '1 : '0;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			io_out_out <= '0;
		end else begin
			io_out_out <= next_io_out;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			io_oe_n_out <= '1;
		end else begin
			io_oe_n_out <= next_io_oe_n;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			io_pullup_out <= '0;
		end else begin
			io_pullup_out <= next_io_pullup;
		end
	end

endmodule : user_nvm_byte_read_port

`default_nettype wire

// ---- verilog/user_nvm_map.svh ----
// constants for the user nonvolatile byte store and its ports
`ifndef USER_NVM_MAP_SVH
`define USER_NVM_MAP_SVH

`define NVM_ADDR_W        7
`define NVM_BANK_W        3
`define NVM_BYTE_W        4
`define NVM_DATA_W        8
`define NVM_BANKS         8
`define NVM_BANK_BITS     128
`define NVM_BYTES_PER_BANK 16
`define NVM_TOTAL_BITS    1024
`define NVM_BANK_MSB      6
`define NVM_BANK_LSB      4
`define NVM_BYTE_MSB      3
`define NVM_BYTE_LSB      0
`define NVM_ERASED_BYTE   8'hff
`define NVM_RD_DATA_RST   8'h00
`define NVM_PROG_DATA_RST 8'h00
`define NVM_KEY_SEED      8'h5a
`define NVM_IO_W          8

`endif

// ---- verilog/user_nvm_pkg.sv ----
// types and address decoding for the user nonvolatile byte store
`default_nettype none
`include "user_nvm_map.svh"

package user_nvm_pkg;

	typedef logic [`NVM_ADDR_W-1:0] nvm_addr_type;
	typedef logic [`NVM_BANK_W-1:0] nvm_bank_type;
	typedef logic [`NVM_BYTE_W-1:0] nvm_index_type;
	typedef logic [`NVM_DATA_W-1:0] nvm_byte_type;

	// gray along idle -> open -> closing; closing -> idle flips both bits
	typedef enum logic [1:0] {
		session_idle    = 2'h0,
		session_open    = 2'h1,
		session_closing = 2'h3
	} session_type;

	function automatic nvm_bank_type bank_of(input nvm_addr_type addr);
		bank_of = addr[`NVM_BANK_MSB:`NVM_BANK_LSB];
	endfunction : bank_of

	function automatic nvm_index_type index_of(input nvm_addr_type addr);
		index_of = addr[`NVM_BYTE_MSB:`NVM_BYTE_LSB];
	endfunction : index_of

endpackage : user_nvm_pkg

`default_nettype wire
